// ==== rtl/iow_pkg.sv ====
// How it works
// - pin toggle wakes both halts; others light only
// - deep halt ignores timer and comparator events
// - normal wake resumes after 3000 slow clocks
// - fast wake resumes after 45 slow clocks
// - fast boot option forces fast; else bit5
// - direction 0 input, 1 drives output data
// - input with pull-high bit gets pull-up
// - only port B bits 3, 6 pull-low
// - both pull bits set enable both resistors
// - driving low turns the pull-up off
// - driving high turns the pull-down off
// - data read gives pad for inputs with digital input enabled (0 if disabled), latch otherwise
// - port A bit 5, port B bit 0 open-drain
// - any eligible pin toggle wakes from halt
// - comparator wake gated by select wake enable
package iow_pkg;
  localparam logic [7:0] OFF_PA_DATA  = 8'h00;
  localparam logic [7:0] OFF_PA_DIR   = 8'h04;
  localparam logic [7:0] OFF_PA_PH    = 8'h08;
  localparam logic [7:0] OFF_PA_DIE   = 8'h0C;
  localparam logic [7:0] OFF_PB_DATA  = 8'h10;
  localparam logic [7:0] OFF_PB_DIR   = 8'h14;
  localparam logic [7:0] OFF_PB_PH    = 8'h18;
  localparam logic [7:0] OFF_PB_PL    = 8'h1C;
  localparam logic [7:0] OFF_PB_DIE   = 8'h20;
  localparam logic [7:0] OFF_MISC     = 8'h24;
  localparam logic [7:0] OFF_CMP_CTRL = 8'h28;
  localparam logic [7:0] OFF_CMP_SEL  = 8'h2C;
  localparam logic [7:0] OFF_HALT     = 8'h30;

  localparam int MISC_FAST_BIT    = 5;
  localparam int CMP_EN_BIT       = 7;
  localparam int CMP_WAKE_BIT     = 6;
  localparam int HALT_LIGHT_BIT   = 0;
  localparam int HALT_DEEP_BIT    = 1;

  localparam logic [7:0] PB_PL_MASK = 8'h48;
  localparam logic [7:0] PA_OD_MASK = 8'h20;
  localparam logic [7:0] PB_OD_MASK = 8'h01;

  localparam logic [7:0] RST_REG8   = 8'h00;
  localparam logic [7:0] RST_DIE    = 8'hFF;

  localparam int WAKE_CNT_W = 12;
  localparam logic [WAKE_CNT_W-1:0] WAKE_NORMAL_TICKS = 12'hBB8;
  localparam logic [WAKE_CNT_W-1:0] WAKE_FAST_TICKS   = 12'h02D;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] pull_high;
    logic [7:0] din_en;
  } iow_port_cfg_t;

  typedef enum logic [1:0] {ST_RUN, ST_LIGHT, ST_DEEP, ST_WAKE} iow_state_t;
endpackage

// ==== rtl/iow_wake_timer.sv ====
`timescale 1ns/1ps
module iow_wake_timer import iow_pkg::*;
#(
  parameter logic [WAKE_CNT_W-1:0] NORMAL_CNT = WAKE_NORMAL_TICKS,
  parameter logic [WAKE_CNT_W-1:0] FAST_CNT   = WAKE_FAST_TICKS
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic start,
  input  wire logic fast,
  input  wire logic tick,
  output logic      busy,
  output logic      done
);
  logic [WAKE_CNT_W-1:0] cnt;
  logic [WAKE_CNT_W-1:0] target;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy   <= 1'b0;
      done   <= 1'b0;
      cnt    <= '0;
      target <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy   <= 1'b1;
        cnt    <= '0;
        target <= fast ? FAST_CNT : NORMAL_CNT;
      end
      else if (busy && tick)
      begin
        cnt <= cnt + 1'b1;
        if (cnt == target - 1'b1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_done_after_target;
    busy && tick && (cnt == target - 1'b1) && !start |=> done && !busy;
  endproperty
  a_done_after_target: assert property (p_done_after_target)
    else $error("wake delay did not end at target");

  property p_no_early_done;
    busy && !start && (cnt < target - 1'b1) |=> !done;
  endproperty
  a_no_early_done: assert property (p_no_early_done)
    else $error("wake delay ended early");
endmodule

// ==== rtl/iow_top.sv ====
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module iow_top import iow_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [7:0]  pa_in,
  output logic [7:0]       pa_out,
  output logic [7:0]       pa_oe,
  output logic [7:0]       pa_pull_up,
  input  wire logic [7:0]  pb_in,
  output logic [7:0]       pb_out,
  output logic [7:0]       pb_oe,
  output logic [7:0]       pb_pull_up,
  output logic [7:0]       pb_pull_down,
  input  wire logic        slow_rc_osc,
  input  wire logic        timer_wake_evt,
  input  wire logic        cmp_wake_evt,
  input  wire logic        fast_boot_opt,
  output logic             core_clk_en,
  output logic             halted
);
  iow_port_cfg_t   port_a;
  iow_port_cfg_t   port_b;
  logic [7:0]      pb_pull_low;
  logic [7:0]      misc;
  logic [7:0]      analog_cmp_control;
  logic [7:0]      analog_cmp_select;
  logic            fast_boot_q;
  logic            wake_by_pin;
  iow_state_t      state;
  logic            wr_pend;
  logic [7:0]      wr_addr;
  logic            addr_ok;
  logic [31:0]     next_rdata;
  logic [15:0]     pin_s1;
  logic [15:0]     pin_s2;
  logic [15:0]     pin_s3;
  logic [15:0]     pin_lvl;
  logic [15:0]     pin_snap;
  logic [15:0]     eligible;
  logic            pin_change;
  logic [2:0]      rc_sync;
  logic            rc_lvl;
  logic            rc_lvl_d;
  logic            rc_tick;
  logic            wake_fast;
  logic            light_evt;
  logic            wake_start;
  logic            wake_busy;
  logic            wake_done;
  logic [7:0]      pa_rd;
  logic [7:0]      pb_rd;
  logic [7:0]      halt_status;

  // zero wait states; every access is answered OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && htrans[1] && hready;

  // agreed level: a bit moves only once stages two and three match
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1  <= '0;
      pin_s2  <= '0;
      pin_s3  <= '0;
      pin_lvl <= '0;
    end
    else
    begin
      pin_s1  <= {pb_in, pa_in};
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pin_lvl <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_lvl & (pin_s2 ^ pin_s3));
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rc_sync  <= 3'h0;
      rc_lvl   <= 1'b0;
      rc_lvl_d <= 1'b0;
    end
    else
    begin
      rc_sync  <= {rc_sync[1:0], slow_rc_osc};
      if (rc_sync[1] == rc_sync[2])
      begin
        rc_lvl <= rc_sync[2];
      end
      rc_lvl_d <= rc_lvl;
    end
  end

  // slow oscillator is sampled, so it must be well below hclk / 6
  assign rc_tick = rc_lvl && !rc_lvl_d;

  // strap follows the pin after release, never loaded under reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fast_boot_q <= 1'b0;
    end
    else
    begin
      fast_boot_q <= fast_boot_opt;
    end
  end

  assign wake_fast = fast_boot_q || misc[MISC_FAST_BIT];

  // pad readback, input path dead when digital input is disabled
  assign pa_rd = (port_a.dir & port_a.data) | (~port_a.dir & pin_lvl[7:0] & port_a.din_en);
  assign pb_rd = (port_b.dir & port_b.data) | (~port_b.dir & pin_lvl[15:8] & port_b.din_en);
  assign halt_status = {4'h0, wake_by_pin, state == ST_WAKE, state == ST_DEEP, state == ST_LIGHT};

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (haddr[7:0])
      OFF_PA_DATA:  next_rdata[7:0] = pa_rd;
      OFF_PA_DIR:   next_rdata[7:0] = port_a.dir;
      OFF_PA_PH:    next_rdata[7:0] = port_a.pull_high;
      OFF_PA_DIE:   next_rdata[7:0] = port_a.din_en;
      OFF_PB_DATA:  next_rdata[7:0] = pb_rd;
      OFF_PB_DIR:   next_rdata[7:0] = port_b.dir;
      OFF_PB_PH:    next_rdata[7:0] = port_b.pull_high;
      OFF_PB_PL:    next_rdata[7:0] = pb_pull_low;
      OFF_PB_DIE:   next_rdata[7:0] = port_b.din_en;
      OFF_MISC:     next_rdata[7:0] = misc;
      OFF_CMP_CTRL: next_rdata[7:0] = analog_cmp_control;
      OFF_CMP_SEL:  next_rdata[7:0] = analog_cmp_select;
      OFF_HALT:     next_rdata[7:0] = halt_status;
      default:      next_rdata = 32'h0000_0000;
    endcase
    if (|haddr[31:8])
    begin
      next_rdata = 32'h0000_0000;
    end
  end

  // read data sampled at the address phase, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata  <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite && !(|haddr[31:8]);
      wr_addr <= haddr[7:0];
      if (addr_ok && !hwrite)
      begin
        hrdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_a             <= '{RST_REG8, RST_REG8, RST_REG8, RST_DIE};
      port_b             <= '{RST_REG8, RST_REG8, RST_REG8, RST_DIE};
      pb_pull_low        <= RST_REG8;
      misc               <= RST_REG8;
      analog_cmp_control <= RST_REG8;
      analog_cmp_select  <= RST_REG8;
    end
    else if (wr_pend)
    begin
      unique case (wr_addr)
        OFF_PA_DATA:  port_a.data       <= hwdata[7:0];
        OFF_PA_DIR:   port_a.dir        <= hwdata[7:0];
        OFF_PA_PH:    port_a.pull_high  <= hwdata[7:0];
        OFF_PA_DIE:   port_a.din_en     <= hwdata[7:0];
        OFF_PB_DATA:  port_b.data       <= hwdata[7:0];
        OFF_PB_DIR:   port_b.dir        <= hwdata[7:0];
        OFF_PB_PH:    port_b.pull_high  <= hwdata[7:0];
        OFF_PB_PL:    pb_pull_low       <= hwdata[7:0] & PB_PL_MASK;
        OFF_PB_DIE:   port_b.din_en     <= hwdata[7:0];
        OFF_MISC:     misc              <= hwdata[7:0];
        OFF_CMP_CTRL: analog_cmp_control <= hwdata[7:0];
        OFF_CMP_SEL:  analog_cmp_select <= hwdata[7:0];
        default:      ;
      endcase
    end
  end

  // pad drive; open-drain bits never drive high
  assign pa_out = port_a.data & ~PA_OD_MASK;
  assign pb_out = port_b.data & ~PB_OD_MASK;
  assign pa_oe  = port_a.dir & ~(PA_OD_MASK & port_a.data);
  assign pb_oe  = port_b.dir & ~(PB_OD_MASK & port_b.data);

  // pulls exist only on inputs, so output low or high drops them
  assign pa_pull_up   = port_a.pull_high & ~port_a.dir;
  assign pb_pull_up   = port_b.pull_high & ~port_b.dir;
  assign pb_pull_down = pb_pull_low & PB_PL_MASK & ~port_b.dir;

  // only inputs with digital input enabled can wake
  assign eligible   = {~port_b.dir & port_b.din_en, ~port_a.dir & port_a.din_en};
  assign pin_change = |((pin_lvl ^ pin_snap) & eligible);
  assign light_evt  = timer_wake_evt
                   || (cmp_wake_evt && analog_cmp_select[CMP_WAKE_BIT]
                       && analog_cmp_control[CMP_EN_BIT]);

  always_comb
  begin
    unique case (state)
      ST_LIGHT: wake_start = pin_change || light_evt;
      ST_DEEP:  wake_start = pin_change;
      default:  wake_start = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state       <= ST_RUN;
      pin_snap    <= '0;
      wake_by_pin <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_RUN:
        begin
          pin_snap <= pin_lvl;
          if (wr_pend && wr_addr == OFF_HALT && hwdata[HALT_DEEP_BIT])
          begin
            state <= ST_DEEP;
          end
          else if (wr_pend && wr_addr == OFF_HALT && hwdata[HALT_LIGHT_BIT])
          begin
            state <= ST_LIGHT;
          end
        end
        ST_LIGHT, ST_DEEP:
        begin
          if (wake_start)
          begin
            state       <= ST_WAKE;
            wake_by_pin <= pin_change;
          end
        end
        ST_WAKE:
        begin
          if (wake_done)
          begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  iow_wake_timer u_wake_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (wake_start),
    .fast    (wake_fast),
    .tick    (rc_tick),
    .busy    (wake_busy),
    .done    (wake_done)
  );

  // system clock held off until the wake count ends
  assign core_clk_en = (state == ST_RUN);
  assign halted      = (state == ST_LIGHT) || (state == ST_DEEP);

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_deep_ignores_others;
    state == ST_DEEP && !pin_change && (timer_wake_evt || cmp_wake_evt) |=> state == ST_DEEP;
  endproperty
  a_deep_ignores_others: assert property (p_deep_ignores_others)
    else $error("deep halt left on a non-pin event");

  property p_light_timer_wakes;
    state == ST_LIGHT && timer_wake_evt |=> state == ST_WAKE && wake_busy;
  endproperty
  a_light_timer_wakes: assert property (p_light_timer_wakes)
    else $error("timer event did not wake light halt");

  property p_pin_wakes;
    halted && pin_change |=> state == ST_WAKE ##0 wake_by_pin;
  endproperty
  a_pin_wakes: assert property (p_pin_wakes)
    else $error("pin toggle did not wake");

  property p_cmp_gated;
    state == ST_LIGHT && !pin_change && !timer_wake_evt
      && !analog_cmp_select[CMP_WAKE_BIT] |=> state == ST_LIGHT;
  endproperty
  a_cmp_gated: assert property (p_cmp_gated)
    else $error("comparator woke without wake enable");

  property p_fast_forced;
    $past(fast_boot_opt) |-> wake_fast;
  endproperty
  a_fast_forced: assert property (p_fast_forced)
    else $error("fast boot did not force fast wake");

  property p_od_never_high;
    !(pa_oe[5] && pa_out[5]) && !(pb_oe[0] && pb_out[0])
      && (pa_oe[5] == (port_a.dir[5] && !port_a.data[5]));
  endproperty
  a_od_never_high: assert property (p_od_never_high)
    else $error("open-drain bit drove high");

  property p_low_no_pullup;
    ((pa_oe & ~pa_out & pa_pull_up) == 8'h00) && ((pb_oe & ~pb_out & pb_pull_up) == 8'h00);
  endproperty
  a_low_no_pullup: assert property (p_low_no_pullup)
    else $error("pull-up on while driving low");

  property p_high_no_pulldown;
    (pb_oe & pb_out & pb_pull_down) == 8'h00;
  endproperty
  a_high_no_pulldown: assert property (p_high_no_pulldown)
    else $error("pull-down on while driving high");

  property p_pd_bits;
    (pb_pull_down & ~PB_PL_MASK) == 8'h00;
  endproperty
  a_pd_bits: assert property (p_pd_bits)
    else $error("pull-down on a bit without one");

  property p_clk_off_while_waking;
    state == ST_WAKE && !wake_done |=> !core_clk_en;
  endproperty
  a_clk_off_while_waking: assert property (p_clk_off_while_waking)
    else $error("clock released before wake delay");

  c_light_timer: cover property (state == ST_LIGHT && timer_wake_evt);
  c_deep_pin:    cover property (state == ST_DEEP && pin_change);
  c_fast_done:   cover property (wake_done && wake_fast);
  c_resume:      cover property (state == ST_WAKE ##1 state == ST_RUN);
endmodule

// ==== test/iow_pin_model.sv ====
`timescale 1ns/1ps
module iow_pin_model
(
  input  wire logic       hclk,
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pa_pull_up,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] pb_pull_up,
  input  wire logic [7:0] pb_pull_down,
  input  wire logic [7:0] board_a,
  input  wire logic [7:0] board_a_en,
  input  wire logic [7:0] board_b,
  input  wire logic [7:0] board_b_en,
  output logic [7:0]      pa_in,
  output logic [7:0]      pb_in
);
  logic float_t = 1'b0;

  // undriven pads wander every cycle so a stale level never passes for a read
  always @(posedge hclk) float_t <= ~float_t;

  function automatic logic [7:0] pad(input logic [7:0] oe, o, be, b, pu, pd, input logic f);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
    begin
      // device drive wins; open-drain release leaves oe low
      if (oe[i]) r[i] = o[i];
      else if (be[i]) r[i] = b[i];
      else if (pu[i]) r[i] = 1'b1;
      else if (pd[i]) r[i] = 1'b0;
      else r[i] = f ^ i[0];
    end
    return r;
  endfunction

  always_comb pa_in = pad(pa_oe, pa_out, board_a_en, board_a, pa_pull_up, 8'h00, float_t);
  always_comb pb_in = pad(pb_oe, pb_out, board_b_en, board_b, pb_pull_up, pb_pull_down, float_t);
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import iow_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  pa_in, pa_out, pa_oe, pa_pull_up, pb_in, pb_out, pb_oe, pb_pull_up, pb_pull_down;
  logic [7:0]  board_a, board_a_en, board_b, board_b_en;
  logic        slow_rc_osc, timer_wake_evt, cmp_wake_evt, fast_boot_opt, core_clk_en, halted;
  int          bad_count, cmp_count, tick_ctr, cyc;

  assign hready = hreadyout;

  iow_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pull_up(pa_pull_up), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_pull_up(pb_pull_up), .pb_pull_down(pb_pull_down), .slow_rc_osc(slow_rc_osc),
    .timer_wake_evt(timer_wake_evt), .cmp_wake_evt(cmp_wake_evt),
    .fast_boot_opt(fast_boot_opt), .core_clk_en(core_clk_en), .halted(halted));

  iow_pin_model PINS (.hclk(hclk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pull_up(pa_pull_up),
    .pb_out(pb_out), .pb_oe(pb_oe), .pb_pull_up(pb_pull_up), .pb_pull_down(pb_pull_down),
    .board_a(board_a), .board_a_en(board_a_en), .board_b(board_b), .board_b_en(board_b_en),
    .pa_in(pa_in), .pb_in(pb_in));

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // slow oscillator at 8 hclk periods, off phase from hclk
  initial
  begin
    slow_rc_osc = 1'b0;
    #3;
    forever #80 slow_rc_osc = ~slow_rc_osc;
  end

  always @(posedge slow_rc_osc) tick_ctr++;

  task close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      bad_count++;
      close_out();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // single transfer; waits on hready in both phases
  task bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    // select stays up; idle htrans keeps the slave inert between calls
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do
    begin
      @(posedge hclk);
    end
    while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do
    begin
      @(posedge hclk);
    end
    while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] v;
    bus({24'h0, a}, 1'b1, {24'h0, d}, v);
    // stored value lands at that edge; let it reach the pads first
    @(posedge hclk);
  endtask

  task rd_chk(input logic [31:0] a, input logic [7:0] exp);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    check(v, {24'h0, exp});
  endtask

  task fire(input int src);
    if (src == 2) board_a <= board_a ^ 8'h02;
    else
    begin
      timer_wake_evt <= (src != 1);
      cmp_wake_evt <= (src != 0);
    end
    @(posedge hclk);
    timer_wake_evt <= 1'b0;
    cmp_wake_evt <= 1'b0;
  endtask

  // halt, fire a source; a refused source is followed by a pin toggle
  task run_halt(input logic [7:0] hv, input int src, input bit wakes, input int ticks);
    int t0, n;
    wr(OFF_HALT, hv);
    repeat (3) @(posedge hclk);
    check({core_clk_en, halted}, 2'b01);
    t0 = tick_ctr;
    fire(src);
    if (!wakes)
    begin
      repeat (40) @(posedge hclk);
      check(halted, 1'b1);
      t0 = tick_ctr;
      fire(2);
    end
    n = 0;
    while (core_clk_en !== 1'b1 && n < 40000)
    begin
      @(posedge hclk);
      n++;
    end
    n = tick_ctr - t0;
    check(n >= ticks - 1 && n <= ticks + 2, 1'b1);
    check(halted, 1'b0);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    board_a = 8'h00;
    board_a_en = 8'hFF;
    board_b = 8'h00;
    board_b_en = 8'hFF;
    timer_wake_evt = 1'b0;
    cmp_wake_evt = 1'b0;
    fast_boot_opt = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({core_clk_en, halted}, 2'b10);
    rd_chk(OFF_PA_DIE, RST_DIE);
    rd_chk(OFF_PA_DIR, RST_REG8);
    rd_chk(OFF_PB_DIE, RST_DIE);
    check({hreadyout, hresp}, 2'b10);
    wr(8'h40, 8'h5A);
    rd_chk(32'h0000_0040, 8'h00);
    rd_chk(32'h0000_0100, 8'h00);
    $display("test reset done");

    // port A: outputs, open-drain bit, pulls, pad readback
    wr(OFF_PA_PH, 8'hFF);
    wr(OFF_PA_DATA, 8'hA5);
    board_a_en <= 8'h00;
    wr(OFF_PA_DIR, 8'hFF);
    check({pa_out, pa_oe, pa_pull_up}, 24'h85DF00);
    rd_chk(OFF_PA_DATA, 8'hA5);
    board_a <= 8'h3C;
    board_a_en <= 8'hF0;
    wr(OFF_PA_DIR, 8'h0F);
    check(pa_pull_up, 8'hF0);
    repeat (6) @(posedge hclk);
    rd_chk(OFF_PA_DATA, 8'h35);
    wr(OFF_PA_DIE, 8'h0F);
    repeat (6) @(posedge hclk);
    rd_chk(OFF_PA_DATA, 8'h05);
    wr(OFF_PA_DIE, 8'hFF);
    wr(OFF_PA_PH, 8'h00);
    wr(OFF_PA_DIR, 8'h00);
    board_a <= 8'h00;
    board_a_en <= 8'hFF;
    $display("test port a done");

    // port B: pull-low bits, both pulls, automatic release
    wr(OFF_PB_PH, 8'hFF);
    wr(OFF_PB_PL, 8'hFF);
    check({pb_pull_up, pb_pull_down}, 16'hFF48);
    rd_chk(OFF_PB_PL, PB_PL_MASK);
    wr(OFF_PB_DATA, 8'hFF);
    board_b_en <= 8'h00;
    wr(OFF_PB_DIR, 8'hFF);
    check({pb_out, pb_oe, pb_pull_down}, 24'hFEFE00);
    wr(OFF_PB_DATA, 8'h00);
    check({pb_out, pb_oe, pb_pull_up}, 24'h00FF00);
    wr(OFF_PB_DIR, 8'h00);
    board_b_en <= 8'hFF;
    $display("test port b done");

    // wake sources per halt mode, fast and normal delay
    wr(OFF_CMP_CTRL, 8'h80);
    wr(OFF_CMP_SEL, 8'h40);
    wr(OFF_MISC, 8'h20);
    run_halt(8'h01, 0, 1'b1, 45);
    run_halt(8'h01, 1, 1'b1, 45);
    run_halt(8'h03, 3, 1'b0, 45);
    rd_chk(OFF_HALT, 8'h08);
    wr(OFF_CMP_SEL, 8'h00);
    run_halt(8'h01, 1, 1'b0, 45);
    wr(OFF_MISC, 8'h00);
    run_halt(8'h01, 2, 1'b1, 3000);
    fast_boot_opt <= 1'b1;
    run_halt(8'h01, 2, 1'b1, 45);
    $display("test wake done");
    close_out();
  end
endmodule
